// File: design/sid_top.sv
// status indicator driver top: management registers and three channels
`timescale 1ns/1ps
`default_nettype none
// Function
// - low enable bits admit sources 15..0, reset zero
// - extension enable bits admit sources 47..32, reset zero
// - blink count sets on/off ticks, resets four
// - tick period is (divider+1) times 10 ns
// - upper divider byte writable, resets all ones
// - lower divider word writable, resets all ones
// - upper divider register bits 15:8 read zero
// - active-high drive disable per indicator, resets one
// - function select: off, blink, steady, open drain
// - steady mode on while combined sources active
// - stretch enable lengthens short source pulses
module sid_top (
    // clock, reset and enable
    input  wire logic                        CORE_CLK_IN,
    input  wire logic                        RST_N_IN,
    input  wire logic                        CE_IN,
    // management register port
    input  wire logic [sid_pkg::ADDR_W-1:0]  MGMT_ADDR_IN,
    input  wire logic                        MGMT_WR_IN,
    input  wire logic                        MGMT_RD_IN,
    input  wire logic [sid_pkg::DATA_W-1:0]  MGMT_WDATA_IN,
    output logic      [sid_pkg::DATA_W-1:0]  MGMT_RDATA_OUT,
    output logic                             MGMT_RVALID_OUT,
    // source pool
    input  wire logic [sid_pkg::NUM_SRC-1:0] SRC_IN,
    // indicator pins 3..5
    output logic      [sid_pkg::NUM_IND-1:0] IND_PIN_OUT,
    output logic      [sid_pkg::NUM_IND-1:0] IND_PIN_OE_OUT
);
    import sid_pkg::*;

    logic [MASK_W-1:0]  mask_lo_q  [NUM_IND];
    logic [MASK_W-1:0]  mask_ext_q [NUM_IND];
    logic [BLINK_W-1:0] blink_q    [NUM_BLK];
    logic [DATA_W-1:0]  div_lo_q;
    logic [DIVH_W-1:0]  div_hi_q;
    logic [DATA_W-1:0]  ctrl_q;
    logic [DATA_W-1:0]  str_q;
    logic [DIV_W-1:0]   div_w;
    logic               tick_w;
    logic               wr_w;
    logic [NUM_IND-1:0] sel_lo;
    logic [NUM_IND-1:0] sel_ext;
    logic [NUM_BLK-1:0] sel_blk;
    logic               sel_div_lo;
    logic               sel_div_hi;
    logic               sel_ctrl;
    logic               sel_str;
    logic [DATA_W-1:0]  rd_d;
    sid_cfg_s           cfg_w [NUM_IND];

    ////////////////////////////////////////////////////////////////////////////
    // address decode
    assign wr_w       = CE_IN & MGMT_WR_IN;
    assign sel_div_lo = MGMT_ADDR_IN == OFS_DIV_LO;
    assign sel_div_hi = MGMT_ADDR_IN == OFS_DIV_HI;
    assign sel_ctrl   = MGMT_ADDR_IN == OFS_CTRL;
    assign sel_str    = MGMT_ADDR_IN == OFS_STRETCH;

    ////////////////////////////////////////////////////////////////////////////
    // shared registers
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            div_lo_q <= RST_DIV_LO;
            div_hi_q <= RST_DIV_HI;
            ctrl_q   <= RST_CTRL;
            str_q    <= RST_STR;
        end else if (wr_w) begin
            if (sel_div_lo) div_lo_q <= MGMT_WDATA_IN;
            // bits 15:8 of the written word are dropped
            if (sel_div_hi) div_hi_q <= MGMT_WDATA_IN[DIVH_W-1:0];
            if (sel_ctrl) ctrl_q <= MGMT_WDATA_IN;
            if (sel_str) str_q <= MGMT_WDATA_IN;
        end
    end

    assign div_w = {div_hi_q, div_lo_q};

    ////////////////////////////////////////////////////////////////////////////
    // blink registers; the reserved 15:4 are not kept and read zero
    for (genvar j = 0; j < NUM_BLK; j++) begin : g_blk
        assign sel_blk[j] = MGMT_ADDR_IN == OFS_BLINK[j];
        always_ff @(posedge CORE_CLK_IN) begin
            if (!RST_N_IN) begin
                blink_q[j] <= RST_BLINK;
            end else if (wr_w && sel_blk[j]) begin
                blink_q[j] <= MGMT_WDATA_IN[BLINK_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per channel registers and channels
    for (genvar i = 0; i < NUM_IND; i++) begin : g_ind
        assign sel_lo[i]  = MGMT_ADDR_IN == OFS_MASK_LO[i];
        assign sel_ext[i] = MGMT_ADDR_IN == OFS_MASK_EXT[i];

        always_ff @(posedge CORE_CLK_IN) begin
            if (!RST_N_IN) begin
                mask_lo_q[i]  <= RST_MASK;
                mask_ext_q[i] <= RST_MASK;
            end else if (wr_w) begin
                if (sel_lo[i]) mask_lo_q[i] <= MGMT_WDATA_IN;
                if (sel_ext[i]) mask_ext_q[i] <= MGMT_WDATA_IN;
            end
        end

        assign cfg_w[i].mask_lo   = mask_lo_q[i];
        assign cfg_w[i].mask_ext  = mask_ext_q[i];
        assign cfg_w[i].blink     = blink_q[i+1];
        assign cfg_w[i].fsel      = ctrl_q[CTRL_FSEL_LSB[i] +: 2];
        assign cfg_w[i].drive_dis = ctrl_q[CTRL_OE_BIT[i]];
        assign cfg_w[i].stretch   = str_q[STRETCH_BIT[i]];

        sid_chan u_chan (
            .clk_in     (CORE_CLK_IN),
            .rst_n_in   (RST_N_IN),
            .ce_in      (CE_IN),
            .tick_in    (tick_w),
            .src_in     (SRC_IN),
            .cfg_in     (cfg_w[i]),
            .pin_out    (IND_PIN_OUT[i]),
            .pin_oe_out (IND_PIN_OE_OUT[i])
        );
    end

    sid_tick u_tick (
        .clk_in   (CORE_CLK_IN),
        .rst_n_in (RST_N_IN),
        .ce_in    (CE_IN),
        .div_in   (div_w),
        .tick_out (tick_w)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read mux; offsets are distinct so the terms never overlap
    always_comb begin
        rd_d = '0;
        if (sel_div_lo) rd_d = rd_d | div_lo_q;
        if (sel_div_hi) rd_d = rd_d | DATA_W'(div_hi_q);
        if (sel_ctrl) rd_d = rd_d | ctrl_q;
        if (sel_str) rd_d = rd_d | str_q;
        for (int j = 0; j < NUM_BLK; j++) begin
            if (sel_blk[j]) rd_d = rd_d | DATA_W'(blink_q[j]);
        end
        for (int i = 0; i < NUM_IND; i++) begin
            if (sel_lo[i]) rd_d = rd_d | mask_lo_q[i];
            if (sel_ext[i]) rd_d = rd_d | mask_ext_q[i];
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            MGMT_RDATA_OUT  <= '0;
            MGMT_RVALID_OUT <= 1'b0;
        end else if (CE_IN) begin
            MGMT_RVALID_OUT <= MGMT_RD_IN;
            if (MGMT_RD_IN) MGMT_RDATA_OUT <= rd_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_div_hi_reserved: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        CE_IN && MGMT_RD_IN && sel_div_hi |=>
            MGMT_RVALID_OUT && MGMT_RDATA_OUT[DATA_W-1:DIVH_W] == '0)
        else $error("upper divider reserved bits read nonzero");

    a_div_lo_written: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        wr_w && sel_div_lo |=> div_w[DATA_W-1:0] == $past(MGMT_WDATA_IN))
        else $error("lower divider word not written");

    a_div_hi_written: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        wr_w && sel_div_hi |=> div_w[DIV_W-1:DATA_W] == $past(MGMT_WDATA_IN[DIVH_W-1:0]))
        else $error("upper divider byte not written");

    a_blink_readback: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        wr_w && sel_blk[1] ##1 CE_IN && MGMT_RD_IN && sel_blk[1] && !MGMT_WR_IN |=>
            MGMT_RDATA_OUT == DATA_W'($past(MGMT_WDATA_IN[BLINK_W-1:0], 2)))
        else $error("blink register readback wrong");

endmodule
`default_nettype wire

// File: design/sid_pkg.sv
// shared constants and carrier types of the status indicator driver
package sid_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // widths and counts
    localparam int ADDR_W   = 16;
    localparam int DATA_W   = 16;
    localparam int NUM_SRC  = 48;
    localparam int NUM_IND  = 3;
    localparam int NUM_BLK  = 4;
    localparam int BLINK_W  = 4;
    localparam int DIV_W    = 24;
    localparam int DIVH_W   = 8;
    localparam int MASK_W   = 16;
    localparam int EXT_LSB  = 32;
    localparam int STR_W    = BLINK_W + 1;
    localparam int ACC_W    = 5;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [ADDR_W-1:0] OFS_DIV_LO  = 16'ha82a;
    localparam logic [ADDR_W-1:0] OFS_DIV_HI  = 16'ha82b;
    localparam logic [ADDR_W-1:0] OFS_CTRL    = 16'ha83b;
    localparam logic [ADDR_W-1:0] OFS_STRETCH = 16'ha8ec;
    // blink registers, index 0 belongs to indicator 2, 1..3 to indicators 3..5
    localparam logic [ADDR_W-1:0] OFS_BLINK [NUM_BLK] =
        '{16'ha831, 16'ha834, 16'ha837, 16'ha83a};
    // per channel, index 0..2 is indicator 3..5
    localparam logic [ADDR_W-1:0] OFS_MASK_LO [NUM_IND]  = '{16'ha832, 16'ha835, 16'ha838};
    localparam logic [ADDR_W-1:0] OFS_MASK_EXT [NUM_IND] = '{16'ha8f1, 16'ha8f2, 16'ha8f3};

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CTRL_OE_BIT [NUM_IND]   = '{8, 11, 14};
    localparam int CTRL_FSEL_LSB [NUM_IND] = '{6, 9, 12};
    localparam int STRETCH_BIT [NUM_IND]   = '{7, 8, 9};

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [MASK_W-1:0]  RST_MASK   = 16'h0000;
    localparam logic [BLINK_W-1:0] RST_BLINK  = 4'h4;
    localparam logic [DATA_W-1:0]  RST_DIV_LO = 16'hffff;
    localparam logic [DIVH_W-1:0]  RST_DIV_HI = 8'hff;
    localparam logic [DATA_W-1:0]  RST_CTRL   = 16'h4924;
    localparam logic [DATA_W-1:0]  RST_STR    = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // function select codes
    localparam logic [1:0] FSEL_OFF    = 2'h0;
    localparam logic [1:0] FSEL_BLINK  = 2'h1;
    localparam logic [1:0] FSEL_STEADY = 2'h2;
    localparam logic [1:0] FSEL_OD     = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // timing: reference period and core clock period in ns
    localparam int REF_PERIOD_NS = 10;
    localparam int CLK_PERIOD_NS = 4;
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(CLK_PERIOD_NS);
    localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(REF_PERIOD_NS);

    ////////////////////////////////////////////////////////////////////////////
    // carrier of one channel's configuration
    typedef struct packed {
        logic [MASK_W-1:0]  mask_lo;
        logic [MASK_W-1:0]  mask_ext;
        logic [BLINK_W-1:0] blink;
        logic [1:0]         fsel;
        logic               drive_dis;
        logic               stretch;
    } sid_cfg_s;

endpackage

// File: design/sid_tick.sv
// slow tick generator: 10 ns reference derived from the core clock, then divided
`timescale 1ns/1ps
`default_nettype none
module sid_tick (
    // clock, reset and enable
    input  wire logic                    clk_in,
    input  wire logic                    rst_n_in,
    input  wire logic                    ce_in,
    // divider value
    input  wire logic [sid_pkg::DIV_W-1:0] div_in,
    // tick pulse
    output logic                         tick_out
);
    import sid_pkg::*;

    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] acc_d;
    logic [ACC_W-1:0] acc_sum;
    logic             ref_w;
    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] cnt_d;

    ////////////////////////////////////////////////////////////////////////////
    // fractional accumulator: 10 ns is not a whole number of 4 ns cycles,
    // so reference pulses come 2 or 3 cycles apart but average exactly 10 ns
    assign acc_sum  = acc_q + ACC_STEP;
    assign ref_w    = ce_in & (acc_sum >= ACC_WRAP);
    assign acc_d    = ref_w ? acc_sum - ACC_WRAP : acc_sum;
    // period is (div + 1) reference periods; >= keeps a lowered divider safe
    assign tick_out = ref_w & (cnt_q >= div_in);
    assign cnt_d    = tick_out ? '0 : (ref_w ? cnt_q + 1'b1 : cnt_q);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            acc_q <= '0;
            cnt_q <= '0;
        end else if (ce_in) begin
            acc_q <= acc_d;
            cnt_q <= cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_tick_clears_count: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        tick_out |=> cnt_q == '0)
        else $error("divider count not cleared after tick");

    a_count_waits_ref: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !ref_w |=> $stable(cnt_q))
        else $error("divider count moved without reference pulse");

    a_ref_spacing: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ref_w |=> !ref_w)
        else $error("reference pulses too close");

endmodule
`default_nettype wire

// File: design/sid_chan.sv
// one indicator channel: source combine, stretch, blink and pin drive
`timescale 1ns/1ps
`default_nettype none
module sid_chan (
    // clock, reset and enable
    input  wire logic                      clk_in,
    input  wire logic                      rst_n_in,
    input  wire logic                      ce_in,
    // slow tick and sources
    input  wire logic                      tick_in,
    input  wire logic [sid_pkg::NUM_SRC-1:0] src_in,
    // configuration
    input  wire sid_pkg::sid_cfg_s         cfg_in,
    // pin
    output logic                           pin_out,
    output logic                           pin_oe_out
);
    import sid_pkg::*;

    logic               hit_lo;
    logic               hit_ext;
    logic               raw_w;
    logic               active_w;
    logic               on_w;
    logic               wrap_w;
    logic [BLINK_W-1:0] blink_w;
    logic [STR_W-1:0]   str_q;
    logic [STR_W-1:0]   str_d;
    logic [BLINK_W-1:0] ph_q;
    logic [BLINK_W-1:0] ph_d;
    logic               off_q;
    logic               off_d;
    logic               pin_d;
    logic               oe_d;

    ////////////////////////////////////////////////////////////////////////////
    // sources 31..16 have no enable here and never reach the pin
    assign hit_lo   = |(src_in[MASK_W-1:0] & cfg_in.mask_lo);
    assign hit_ext  = |(src_in[EXT_LSB +: MASK_W] & cfg_in.mask_ext);
    assign raw_w    = hit_lo | hit_ext;
    assign blink_w  = cfg_in.blink;

    // stretch holds a short pulse for one full on+off blink cycle
    assign str_d    = raw_w ? {blink_w, 1'b0}
                    : ((tick_in && str_q != '0) ? str_q - 1'b1 : str_q);
    assign active_w = raw_w | (cfg_in.stretch & (str_q != '0));

    // blink counter; a count of 0 behaves like 1
    assign wrap_w   = ({1'b0, ph_q} + 5'h01) >= {1'b0, blink_w};
    assign ph_d     = !active_w ? '0 : (tick_in ? (wrap_w ? '0 : ph_q + 1'b1) : ph_q);
    assign off_d    = !active_w ? 1'b0 : ((tick_in && wrap_w) ? !off_q : off_q);

    assign on_w     = (cfg_in.fsel == FSEL_BLINK)  ? (active_w & !off_q)
                    : (cfg_in.fsel == FSEL_STEADY) ? active_w
                    : (cfg_in.fsel == FSEL_OD)     ? active_w
                    : 1'b0;
    // open drain only pulls low, and only while on
    assign pin_d    = (cfg_in.fsel == FSEL_OD) ? 1'b0 : on_w;
    assign oe_d     = !cfg_in.drive_dis & ((cfg_in.fsel != FSEL_OD) | on_w);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            str_q      <= '0;
            ph_q       <= '0;
            off_q      <= 1'b0;
            pin_out    <= 1'b0;
            pin_oe_out <= 1'b0;
        end else if (ce_in) begin
            str_q      <= str_d;
            ph_q       <= ph_d;
            off_q      <= off_d;
            pin_out    <= pin_d;
            pin_oe_out <= oe_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence s_blink_wrap;
        ce_in && active_w && tick_in && wrap_w && cfg_in.fsel == FSEL_BLINK;
    endsequence
    sequence s_phase_flipped;
        off_q != $past(off_q) && ph_q == '0;
    endsequence

    a_blink_toggle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_blink_wrap |=> s_phase_flipped)
        else $error("blink phase did not flip at count end");

    a_off_forces_low: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ce_in && cfg_in.fsel == FSEL_OFF |=> !pin_out)
        else $error("off mode drove pin high");

    a_steady_follows: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ce_in && cfg_in.fsel == FSEL_STEADY && active_w |=> pin_out)
        else $error("steady mode not on while active");

    a_steady_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ce_in && cfg_in.fsel == FSEL_STEADY && !active_w |=> !pin_out)
        else $error("steady mode on while inactive");

    a_drive_disabled: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ce_in && cfg_in.drive_dis |=> !pin_oe_out)
        else $error("pin driven while disabled");

    a_od_pulls_low: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ce_in && cfg_in.fsel == FSEL_OD |=> !pin_out && (pin_oe_out == $past(oe_d)))
        else $error("open drain drove high");

    a_stretch_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ce_in && raw_w |=> str_q == {$past(blink_w), 1'b0})
        else $error("stretch count not loaded");

    a_masked_no_hit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        cfg_in.mask_lo == '0 && cfg_in.mask_ext == '0 |-> !raw_w)
        else $error("source hit with all enables clear");

endmodule
`default_nettype wire

// File: dv/tb_sid_top.sv
// self-checking bench of the status indicator driver top
`timescale 1ns/1ps
`default_nettype none
module tb_sid_top;
    import sid_pkg::*;
    typedef struct {logic [15:0] a; logic w; logic [15:0] d; logic [15:0] e;} sid_row_s;
    // slow tick of 10 reference periods, exact in core cycles
    localparam int DIVS = 9;
    localparam int TICK = (DIVS + 1) * REF_PERIOD_NS / CLK_PERIOD_NS;
    logic               clk;
    logic               rst_n;
    logic               ce;
    logic               wr;
    logic               rd;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  wdata;
    logic [DATA_W-1:0]  rdata;
    logic [DATA_W-1:0]  v;
    logic               rvalid;
    logic [NUM_SRC-1:0] src;
    logic [NUM_IND-1:0] pin;
    logic [NUM_IND-1:0] oe;
    int                 errors;
    int                 cmp_count;
    int                 cyc;
    int                 n;
    sid_row_s           rows[$];
    int                 srcb[6] = '{0, 2, 20, 47, 32, 15};
    logic [5:0]         sexp = 6'b101001;
    logic [1:0]         cds[3] = '{FSEL_OFF, FSEL_STEADY, FSEL_OD};

    sid_top uut (
        .CORE_CLK_IN     (clk),
        .RST_N_IN        (rst_n),
        .CE_IN           (ce),
        .MGMT_ADDR_IN    (addr),
        .MGMT_WR_IN      (wr),
        .MGMT_RD_IN      (rd),
        .MGMT_WDATA_IN   (wdata),
        .MGMT_RDATA_OUT  (rdata),
        .MGMT_RVALID_OUT (rvalid),
        .SRC_IN          (src),
        .IND_PIN_OUT     (pin),
        .IND_PIN_OE_OUT  (oe)
    );

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // hang guard, well above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            close_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("mismatches %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask

    task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk("rvalid", 16'(rvalid), 16'h1);
        d = rdata;
    endtask

    // read-modify-write keeps the unused control bits as they stand
    task automatic set_mode(input int ch, input logic [1:0] code, input logic dis);
        logic [15:0] c;
        rd_reg(OFS_CTRL, c);
        c[CTRL_FSEL_LSB[ch] +: 2] = code;
        c[CTRL_OE_BIT[ch]] = dis;
        wr_reg(OFS_CTRL, c);
    endtask

    task automatic measure(input logic val, output int k);
        k = 0;
        while (pin[0] === val && k < 400) begin
            @(negedge clk);
            k++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 16'h0000;
        wdata = 16'h0000;
        src = 48'h0;
        repeat (4) @(negedge clk);
        chk("pin rst", 16'(pin), 16'h0000);
        chk("oe rst", 16'(oe), 16'h0000);
        rst_n = 1'b1;
        for (int i = 0; i < NUM_IND; i++) begin
            rows.push_back('{OFS_MASK_LO[i], 1'b0, 16'h0000, 16'h0000});
            rows.push_back('{OFS_MASK_EXT[i], 1'b0, 16'h0000, 16'h0000});
        end
        for (int i = 0; i < NUM_BLK; i++)
            rows.push_back('{OFS_BLINK[i], 1'b0, 16'h0000, 16'h0004});
        rows.push_back('{OFS_DIV_LO, 1'b0, 16'h0000, 16'hffff});
        rows.push_back('{OFS_DIV_HI, 1'b0, 16'h0000, 16'h00ff});
        rows.push_back('{OFS_CTRL, 1'b0, 16'h0000, 16'h4924});
        rows.push_back('{OFS_STRETCH, 1'b0, 16'h0000, 16'h0000});
        rows.push_back('{OFS_MASK_LO[1], 1'b1, 16'ha5c3, 16'ha5c3});
        rows.push_back('{OFS_MASK_EXT[1], 1'b1, 16'h8000, 16'h8000});
        rows.push_back('{OFS_BLINK[0], 1'b1, 16'hfffa, 16'h000a});
        rows.push_back('{OFS_DIV_HI, 1'b1, 16'habcd, 16'h00cd});
        rows.push_back('{OFS_DIV_LO, 1'b1, 16'h1234, 16'h1234});
        rows.push_back('{16'ha833, 1'b1, 16'hbeef, 16'h0000});
        foreach (rows[i]) begin
            if (rows[i].w)
                wr_reg(rows[i].a, rows[i].d);
            rd_reg(rows[i].a, v);
            chk($sformatf("reg %h", rows[i].a), v, rows[i].e);
        end
        // single sources into indicator 4, steady mode
        set_mode(1, FSEL_STEADY, 1'b0);
        foreach (srcb[i]) begin
            @(negedge clk);
            src = 48'h1 << srcb[i];
            @(negedge clk);
            chk($sformatf("src %0d", srcb[i]), 16'(pin[1]), 16'(sexp[i]));
        end
        // off, steady and open drain with source idle and active
        for (int c = 0; c < 3; c++) begin
            for (int s = 0; s < 2; s++) begin
                set_mode(1, cds[c], 1'b0);
                src = (s == 1) ? 48'h1 : 48'h0;
                repeat (2) @(negedge clk);
                chk("fsel pin", 16'(pin[1]), 16'(cds[c] == FSEL_STEADY && s == 1));
                chk("fsel oe", 16'(oe[1]), 16'((cds[c] == FSEL_OD) ? s : 1));
            end
        end
        set_mode(1, FSEL_STEADY, 1'b1);
        repeat (2) @(negedge clk);
        chk("oe off", 16'(oe[1]), 16'h0000);
        // blink on indicator 3: two ticks on, two ticks off
        wr_reg(OFS_DIV_HI, 16'h0000);
        wr_reg(OFS_DIV_LO, 16'(DIVS));
        wr_reg(OFS_BLINK[1], 16'h0002);
        wr_reg(OFS_MASK_LO[0], 16'h0001);
        set_mode(0, FSEL_BLINK, 1'b0);
        src = 48'h1;
        measure(1'b0, n);
        measure(1'b1, n);
        measure(1'b0, n);
        chk("blink off", 16'(n), 16'(2 * TICK));
        measure(1'b1, n);
        chk("blink on", 16'(n), 16'(2 * TICK));
        // one-cycle pulse stretched over two ticks of one count
        wr_reg(OFS_BLINK[1], 16'h0001);
        wr_reg(OFS_STRETCH, 16'h1 << STRETCH_BIT[0]);
        set_mode(0, FSEL_STEADY, 1'b0);
        src = 48'h0;
        repeat (3) @(negedge clk);
        src = 48'h1;
        @(negedge clk);
        src = 48'h0;
        repeat (10) @(negedge clk);
        chk("stretch on", 16'(pin[0]), 16'h0001);
        repeat (60) @(negedge clk);
        chk("stretch end", 16'(pin[0]), 16'h0000);
        // write then read on the next edge sees the new count
        @(negedge clk);
        addr = OFS_BLINK[1];
        wdata = 16'hfff7;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk("b2b rvalid", 16'(rvalid), 16'h0001);
        chk("b2b blink", rdata, 16'h0007);
        // write while frozen is dropped
        ce = 1'b0;
        wr_reg(OFS_MASK_LO[2], 16'hffff);
        ce = 1'b1;
        rd_reg(OFS_MASK_LO[2], v);
        chk("ce low", v, 16'h0000);
        // second reset in mid-run restores defaults
        @(negedge clk);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        chk("oe rst2", 16'(oe), 16'h0000);
        rst_n = 1'b1;
        rd_reg(OFS_CTRL, v);
        chk("ctrl rst2", v, 16'h4924);
        rd_reg(OFS_DIV_LO, v);
        chk("div rst2", v, 16'hffff);
        close_out;
    end
endmodule
`default_nettype wire
